// ---- standby_pkg.sv ----
// Shared constants and types of the standby controller.
package standby_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_SETTLE_SEL = 8'h00;
    localparam logic [7:0] OFS_CLOCK_CTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_EVENTS = 8'h0C;
    localparam logic [7:0] OFS_RELEASE_COUNT = 8'h10;

    // Field layout of the clock control register.
    localparam int CLK_SUB_EN_BIT = 0;
    localparam int CLK_LOW_OSC_EN_BIT = 1;
    localparam int CLK_TIMER_SUB_BIT = 2;

    // Field layout of the event register.
    localparam int EVT_STOP_REFUSED_BIT = 0;
    localparam int EVT_INT_RELEASE_BIT = 1;
    localparam int EVT_RESET_RELEASE_BIT = 2;

    // Field layout of the status register.
    localparam int STS_STATE_LSB = 0;
    localparam int STS_SERVICE_BIT = 4;
    localparam int STS_STANDBY_BIT = 5;

    // Reset values.
    localparam logic [2:0] SETTLE_SEL_RESET = 3'h0;
    localparam logic [2:0] CLOCK_CTRL_RESET = 3'h3;
    localparam logic [2:0] EVENTS_RESET = 3'h0;
    localparam logic [7:0] RELEASE_COUNT_RESET = 8'h00;

    // Highest settle select code; larger codes are clamped to it.
    localparam logic [2:0] SETTLE_SEL_MAX = 3'h4;

    // Release waits in core clocks, loaded into the wait counter.
    localparam int WAIT_VECTORED_CLOCKS = 10;
    localparam int WAIT_NEXT_CLOCKS = 3;

    // Width of the wait counter.
    localparam int WAIT_CNT_W = 20;

    // AHB encodings used by the slave.
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_HALT,
        ST_STOP,
        ST_SETTLE,
        ST_RELEASE
    } standby_state_t;

endpackage

// ---- wait_counter.sv ----
// Down counter that pulses when a loaded number of clocks has elapsed.
`timescale 1ns/1ns
module wait_counter #(
    parameter int W = 20
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // Result
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } cnt_state_t;

    cnt_state_t s_q;
    cnt_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (load) begin
            s_d.cnt = load_val;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
            s_d.done = (s_q.cnt == {{(W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
endmodule // wait_counter

// ---- ahb_reg_port.sv ----
// AHB-Lite slave front end turning bus transfers into register strobes.
`timescale 1ns/1ns
module ahb_reg_port (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register side
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data
);
    import standby_pkg::*;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic rd_pend;
        logic [7:0] rd_addr;
        logic [31:0] rdata;
        logic ready;
    } bus_state_t;

    bus_state_t s_q;
    bus_state_t s_d;
    logic take;

    // A read that follows a write directly waits one cycle, so it sees the new value.
    always_comb begin
        s_d = s_q;
        take = hsel && htrans[1] && hready;
        s_d.wr_pend = take && hwrite && (hsize == HSIZE_WORD);
        if (take && hwrite) begin
            s_d.wr_addr = haddr[7:0];
        end
        if (s_q.rd_pend) begin
            s_d.rdata = rd_data;
            s_d.rd_pend = 1'b0;
            s_d.ready = 1'b1;
        end else if (take && !hwrite) begin
            if (s_q.wr_pend) begin
                s_d.rd_pend = 1'b1;
                s_d.rd_addr = haddr[7:0];
                s_d.ready = 1'b0;
            end else begin
                s_d.rdata = rd_data;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{default: '0, ready: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_addr = s_q.rd_pend ? s_q.rd_addr : haddr[7:0];
    assign wr_en = s_q.wr_pend;
    assign wr_addr = s_q.wr_addr;
    assign wr_data = hwdata;
    assign hreadyout = s_q.ready;
    assign hresp = HRESP_OKAY;
    assign hrdata = s_q.rdata;
endmodule // ahb_reg_port

// ---- standby_halt_stop_control.sv ----
// Standby controller: HALT release, STOP entry and clock gating of the core.
//
// Operation
// - Unmasked interrupt ends HALT, service or next.
// - Vectored release waits ten or eleven clocks.
// - Non-vectored release waits three or four clocks.
// - Reset in HALT ends standby, fetches reset vector.
// - Mask, rank, accept, in-service flags decide release.
// - STOP only by instruction from main clock.
// - Pending request turns STOP into HALT, settle wait.
// - STOP gates core clock, oscillators, flash.
// - STOP keeps subclock, low-speed oscillator, RAM, ports.
// - Timer counts in STOP only on subsystem clock.
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module standby_halt_stop_control #(
    parameter int SETTLE_BASE_CYCLES = 2048
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Core instruction events
    input wire logic halt_exec,
    input wire logic stop_exec,
    input wire logic cpu_on_main_clock,
    input wire logic reset_req,
    // Interrupt controller
    input wire logic int_request,
    input wire logic request_mask_flag,
    input wire logic low_rank_flag,
    input wire logic global_accept_flag,
    input wire logic in_service_level_flag,
    // Clock and memory controls
    output logic cpu_clock_en,
    output logic high_speed_osc_en,
    output logic main_crystal_osc_en,
    output logic ext_main_clock_valid,
    output logic flash_en,
    output logic subsystem_clock_en,
    output logic low_speed_osc_en,
    output logic timer16_count_en,
    output logic ram_retain,
    output logic port_latch_hold,
    // Resume events to the core
    output logic vector_service,
    output logic resume_next,
    output logic reset_vector_fetch,
    output logic standby_active
);
    import standby_pkg::*;

    typedef struct packed {
        standby_state_t st;
        logic svc;

        // Software registers.
        logic [2:0] settle_sel;
        logic [2:0] clk_ctrl;
        logic [2:0] events;
        logic [7:0] release_count;

        // Output flops.
        logic cpu_clk;
        logic hs_osc;
        logic x1_osc;
        logic ext_valid;
        logic flash;
        logic sub_clk;
        logic low_osc;
        logic timer_en;
        logic ram_hold;
        logic port_hold;
        logic vec;
        logic nxt;
        logic rst_fetch;
        logic standby;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;

    // Register strobes from the bus front end.
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;

    // Wait counter handshake.
    logic cnt_load;
    logic [WAIT_CNT_W-1:0] cnt_val;
    logic cnt_done;

    // Release decision terms.
    logic unmasked;
    logic service;
    logic [2:0] sel_clamped;
    logic [WAIT_CNT_W-1:0] settle_len;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;

    ahb_reg_port u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    wait_counter #(
        .W(WAIT_CNT_W)
    ) u_wait (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(cnt_load),
        .load_val(cnt_val),
        .done(cnt_done)
    );

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            OFS_SETTLE_SEL: begin
                rd_data[2:0] = s_q.settle_sel;
            end

            OFS_CLOCK_CTRL: begin
                rd_data[2:0] = s_q.clk_ctrl;
            end

            OFS_STATUS: begin
                rd_data[STS_STATE_LSB +: 3] = s_q.st;
                rd_data[STS_SERVICE_BIT] = s_q.svc;
                rd_data[STS_STANDBY_BIT] = s_q.standby;
            end

            OFS_EVENTS: begin
                rd_data[2:0] = s_q.events;
            end

            OFS_RELEASE_COUNT: begin
                rd_data[7:0] = s_q.release_count;
            end

            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        cnt_load = 1'b0;
        cnt_val = '0;
        ev_set = 3'h0;
        ev_clr = 3'h0;
        s_d.vec = 1'b0;
        s_d.nxt = 1'b0;
        s_d.rst_fetch = 1'b0;

        unmasked = int_request && !request_mask_flag;
        // A high-rank request needs only the accept flag; a low-rank one needs in-service too.
        service = global_accept_flag && (!low_rank_flag || in_service_level_flag);

        sel_clamped = (s_q.settle_sel > SETTLE_SEL_MAX) ? SETTLE_SEL_MAX : s_q.settle_sel;
        settle_len = WAIT_CNT_W'(SETTLE_BASE_CYCLES) << sel_clamped;

        if (wr_en) begin
            case (wr_addr)
                OFS_SETTLE_SEL: begin
                    s_d.settle_sel = wr_data[2:0];
                end

                OFS_CLOCK_CTRL: begin
                    s_d.clk_ctrl = wr_data[2:0];
                end

                OFS_EVENTS: begin
                    ev_clr = wr_data[2:0];
                end

                default: begin
                    s_d.settle_sel = s_q.settle_sel;
                end
            endcase
        end

        case (s_q.st)
            ST_RUN: begin
                if (stop_exec && cpu_on_main_clock) begin
                    if (unmasked) begin
                        // STOP is skipped at once; oscillators stay up for the settle wait, then HALT follows.
                        s_d.st = ST_SETTLE;
                        cnt_load = 1'b1;
                        cnt_val = settle_len;
                    end else begin
                        s_d.st = ST_STOP;
                    end
                end else if (stop_exec) begin
                    ev_set[EVT_STOP_REFUSED_BIT] = 1'b1;
                end else if (halt_exec) begin
                    s_d.st = ST_HALT;
                end
            end

            ST_HALT: begin
                if (unmasked) begin
                    s_d.st = ST_RELEASE;
                    s_d.svc = service;
                    cnt_load = 1'b1;
                    if (service) begin
                        cnt_val = WAIT_CNT_W'(WAIT_VECTORED_CLOCKS);
                    end else begin
                        cnt_val = WAIT_CNT_W'(WAIT_NEXT_CLOCKS);
                    end
                end
            end

            ST_STOP: begin
                if (unmasked) begin
                    s_d.st = ST_SETTLE;
                    cnt_load = 1'b1;
                    cnt_val = settle_len;
                end
            end

            ST_SETTLE: begin
                if (cnt_done) begin
                    s_d.st = ST_HALT;
                end
            end

            ST_RELEASE: begin
                if (cnt_done) begin
                    s_d.st = ST_RUN;
                    s_d.vec = s_q.svc;
                    s_d.nxt = !s_q.svc;
                    ev_set[EVT_INT_RELEASE_BIT] = 1'b1;
                    s_d.release_count = s_q.release_count + 8'h01;
                end
            end

            default: begin
                s_d.st = ST_RUN;
            end
        endcase

        // Reset overrides every state and restarts from the reset vector.
        if (reset_req) begin
            if (s_q.st != ST_RUN) begin
                ev_set[EVT_RESET_RELEASE_BIT] = 1'b1;
            end
            s_d.st = ST_RUN;
            s_d.svc = 1'b0;
            s_d.vec = 1'b0;
            s_d.nxt = 1'b0;
            s_d.rst_fetch = 1'b1;
            cnt_load = 1'b1;
            cnt_val = '0;
        end

        // A hardware event in the same cycle as its clear stays set.
        s_d.events = (s_q.events & ~ev_clr) | ev_set;

        // Outputs follow the next state so each one leaves a flip-flop.
        s_d.cpu_clk = (s_d.st == ST_RUN);
        s_d.hs_osc = (s_d.st != ST_STOP);
        s_d.x1_osc = (s_d.st != ST_STOP);
        s_d.ext_valid = (s_d.st != ST_STOP);
        s_d.flash = (s_d.st != ST_STOP);
        // Sub clock and low-speed oscillator follow software only, so STOP leaves them as they were.
        s_d.sub_clk = s_d.clk_ctrl[CLK_SUB_EN_BIT];
        s_d.low_osc = s_d.clk_ctrl[CLK_LOW_OSC_EN_BIT];
        s_d.ram_hold = (s_d.st == ST_STOP);
        s_d.port_hold = (s_d.st == ST_STOP);
        s_d.timer_en = (s_d.st != ST_STOP) || s_d.clk_ctrl[CLK_TIMER_SUB_BIT];
        s_d.standby = (s_d.st != ST_RUN);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{
                st: ST_RUN,
                settle_sel: SETTLE_SEL_RESET,
                clk_ctrl: CLOCK_CTRL_RESET,
                events: EVENTS_RESET,
                release_count: RELEASE_COUNT_RESET,
                cpu_clk: 1'b1,
                hs_osc: 1'b1,
                x1_osc: 1'b1,
                ext_valid: 1'b1,
                flash: 1'b1,
                sub_clk: 1'b1,
                low_osc: 1'b1,
                timer_en: 1'b1,
                default: '0
            };
        end else begin
            s_q <= s_d;
        end
    end

    assign cpu_clock_en = s_q.cpu_clk;
    assign high_speed_osc_en = s_q.hs_osc;
    assign main_crystal_osc_en = s_q.x1_osc;
    assign ext_main_clock_valid = s_q.ext_valid;
    assign flash_en = s_q.flash;
    assign subsystem_clock_en = s_q.sub_clk;
    assign low_speed_osc_en = s_q.low_osc;
    assign timer16_count_en = s_q.timer_en;
    assign ram_retain = s_q.ram_hold;
    assign port_latch_hold = s_q.port_hold;

    assign vector_service = s_q.vec;
    assign resume_next = s_q.nxt;
    assign reset_vector_fetch = s_q.rst_fetch;
    assign standby_active = s_q.standby;
endmodule // standby_halt_stop_control

// ---- standby_chk.sv ----
// Port-level assertions of the standby controller.
`timescale 1ns/1ns
module standby_chk (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Core and interrupt side
    input wire logic stop_exec,
    input wire logic cpu_on_main_clock,
    input wire logic reset_req,
    input wire logic int_request,
    input wire logic request_mask_flag,
    input wire logic low_rank_flag,
    input wire logic global_accept_flag,
    input wire logic in_service_level_flag,
    // Clock controls and resume events
    input wire logic cpu_clock_en,
    input wire logic high_speed_osc_en,
    input wire logic main_crystal_osc_en,
    input wire logic ext_main_clock_valid,
    input wire logic flash_en,
    input wire logic subsystem_clock_en,
    input wire logic low_speed_osc_en,
    input wire logic timer16_count_en,
    input wire logic ram_retain,
    input wire logic port_latch_hold,
    input wire logic vector_service,
    input wire logic resume_next,
    input wire logic reset_vector_fetch,
    input wire logic standby_active
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire unm = int_request & ~request_mask_flag;
    wire svc = global_accept_flag & (~low_rank_flag | in_service_level_flag);
    // Standby with the main clocks up covers halt, settle and release alike.
    wire hlt = standby_active & high_speed_osc_en;
    wire run_stop = stop_exec & cpu_on_main_clock & cpu_clock_en & ~reset_req;

    vec_wait_a:
        assert property (hlt && !unm ##1 hlt && unm && svc && !reset_req
            |=> !vector_service [*8] ##4 vector_service) else $error("vectored wait wrong");
    next_wait_a:
        assert property (hlt && !unm ##1 hlt && unm && !svc && !reset_req
            |=> !resume_next [*3] ##2 resume_next) else $error("next wait wrong");
    mask_hold_a:
        assert property ((hlt && request_mask_flag) [*8] |=> !vector_service && !resume_next)
            else $error("masked request released halt");
    reset_fetch_a:
        assert property (reset_req |=> reset_vector_fetch && cpu_clock_en && !standby_active)
            else $error("reset not taken");
    stop_refuse_a:
        assert property (stop_exec && !cpu_on_main_clock && cpu_clock_en && !reset_req
            |=> high_speed_osc_en && flash_en) else $error("stop entered off main clock");
    stop_gate_a:
        assert property (run_stop && !unm |=> !high_speed_osc_en && !main_crystal_osc_en
            && !ext_main_clock_valid && !flash_en && !cpu_clock_en) else $error("stop gating wrong");
    fall_back_a:
        assert property (run_stop && unm |=> high_speed_osc_en && standby_active && !cpu_clock_en)
            else $error("pending request did not hold off stop");
    stop_keep_a:
        assert property (!high_speed_osc_en |-> ram_retain && port_latch_hold
            && $stable(subsystem_clock_en) && $stable(low_speed_osc_en)) else $error("stop lost state");
    timer_run_a:
        assert property (high_speed_osc_en |-> timer16_count_en) else $error("timer stopped");
    resume_rose_a:
        assert property ($rose(cpu_clock_en) |-> vector_service || resume_next || reset_vector_fetch)
            else $error("core clock resumed without event");
    pulse_run_a:
        assert property (vector_service || resume_next |-> cpu_clock_en && !standby_active
            ##1 !vector_service && !resume_next) else $error("resume pulse wrong");

    cover property (vector_service);
    cover property (resume_next);
    cover property (!high_speed_osc_en ##1 high_speed_osc_en);
endmodule // standby_chk

bind standby_halt_stop_control standby_chk chk_u (.hclk, .hresetn, .stop_exec,
    .cpu_on_main_clock, .reset_req, .int_request, .request_mask_flag, .low_rank_flag,
    .global_accept_flag, .in_service_level_flag, .cpu_clock_en, .high_speed_osc_en,
    .main_crystal_osc_en, .ext_main_clock_valid, .flash_en, .subsystem_clock_en,
    .low_speed_osc_en, .timer16_count_en, .ram_retain, .port_latch_hold, .vector_service,
    .resume_next, .reset_vector_fetch, .standby_active);

// ---- irq_partner.sv ----
// Behavioural interrupt controller and reset source facing the standby controller.
`timescale 1ns/1ns
module irq_partner (
    // Clock and resume events
    input wire logic hclk,
    input wire logic vector_service,
    input wire logic resume_next,
    // Request flags and reset source
    output logic int_request = 1'b0,
    output logic request_mask_flag = 1'b0,
    output logic low_rank_flag = 1'b0,
    output logic global_accept_flag = 1'b0,
    output logic in_service_level_flag = 1'b0,
    output logic reset_req = 1'b0,
    // Cycles an unmasked request has been pending
    output int age = 0
);
    // Pin-clocked peripherals are never started from here on the subsystem clock.
    always @(posedge hclk) begin
        age <= (int_request && !request_mask_flag) ? age + 1 : 0;
        // Acknowledge drops the flag, so a fresh halt is not released at once.
        if (vector_service || resume_next) begin
            int_request <= 1'b0;
        end
    end

    // A gap of zero answers at once; a longer gap models a slow source.
    task automatic raise(input logic [3:0] f, input int gap);
        repeat (gap) @(posedge hclk);
        {request_mask_flag, low_rank_flag, global_accept_flag, in_service_level_flag} <= f;
        int_request <= 1'b1;
    endtask

    task automatic unmask();
        request_mask_flag <= 1'b0;
    endtask

    task automatic pulse_reset();
        reset_req <= 1'b1;
        @(posedge hclk);
        reset_req <= 1'b0;
    endtask
endmodule // irq_partner

// ---- tb_top.sv ----
// Self-checking bench of the standby controller with an interrupt source model.
`timescale 1ns/1ns
module tb_top;
    import standby_pkg::*;
    typedef struct {string nm; logic [31:0] v;} note_t;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, halt_exec = 0, stop_exec = 0;
    logic cpu_on_main_clock = 1, probe = 0, rd_pend = 0;
    logic [31:0] haddr = '0, hwdata = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = '0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, vector_service, resume_next, reset_vector_fetch, standby_active;
    logic cpu_clock_en, high_speed_osc_en, main_crystal_osc_en, ext_main_clock_valid, flash_en;
    logic subsystem_clock_en, low_speed_osc_en, timer16_count_en, ram_retain, port_latch_hold;
    logic int_request, request_mask_flag, low_rank_flag, global_accept_flag;
    logic in_service_level_flag, reset_req;
    int age;
    int num_errors = 0, tests_run = 0;
    note_t exp_q[$];
    wire [10:0] lvl = {cpu_clock_en, high_speed_osc_en, main_crystal_osc_en, ext_main_clock_valid,
        flash_en, subsystem_clock_en, low_speed_osc_en, timer16_count_en, ram_retain,
        port_latch_hold, standby_active};

    always #5 hclk = ~hclk;

    standby_halt_stop_control #(.SETTLE_BASE_CYCLES(4)) dut_u (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata,
        .halt_exec, .stop_exec, .cpu_on_main_clock, .reset_req, .int_request, .request_mask_flag,
        .low_rank_flag, .global_accept_flag, .in_service_level_flag, .cpu_clock_en,
        .high_speed_osc_en, .main_crystal_osc_en, .ext_main_clock_valid, .flash_en,
        .subsystem_clock_en, .low_speed_osc_en, .timer16_count_en, .ram_retain, .port_latch_hold,
        .vector_service, .resume_next, .reset_vector_fetch, .standby_active);

    irq_partner irq_u (.hclk, .vector_service, .resume_next, .int_request, .request_mask_flag,
        .low_rank_flag, .global_accept_flag, .in_service_level_flag, .reset_req, .age);

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen);
        note_t n = '{"none", 'x};
        tests_run++;
        if (exp_q.size() != 0) begin
            n = exp_q.pop_front();
        end
        if (n.nm != nm || n.v !== seen) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, n.v, seen);
        end
    endtask

    task automatic note(input string nm, input logic [31:0] v);
        exp_q.push_back('{nm, v});
    endtask

    // Results are sampled before the edge's own updates land.
    always @(posedge hclk) begin
        if (rd_pend && hreadyout) begin
            chk("hrdata", hrdata);
        end
        if (hreadyout) begin
            rd_pend <= hsel && htrans[1] && !hwrite;
        end
        if (vector_service || resume_next || reset_vector_fetch) begin
            chk("resume", {21'h0, vector_service, resume_next, reset_vector_fetch, age[7:0]});
        end
        if (probe) begin
            chk("levels", {21'h0, lvl});
        end
    end

    task automatic rdy();
        int i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1 || hresp !== HRESP_OKAY) begin
            num_errors++;
            end_of_test();
        end
    endtask

    task automatic drain(input int lim);
        for (int i = 0; i < lim && exp_q.size() != 0; i++) @(posedge hclk);
        if (exp_q.size() != 0) begin
            num_errors++;
            end_of_test();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        hsize <= HSIZE_WORD;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        note("hrdata", e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic look(input logic [10:0] e);
        note("levels", {21'h0, e});
        probe <= 1'b1;
        @(posedge hclk);
        probe <= 1'b0;
    endtask

    task automatic pulse_halt();
        halt_exec <= 1'b1;
        @(posedge hclk);
        halt_exec <= 1'b0;
    endtask

    initial begin
        logic [2:0] rows[5] = '{3'b000, 3'b010, 3'b101, 3'b100, 3'b111};
        logic [2:0] dc[5] = '{3'b001, 3'b001, 3'b000, 3'b010, 3'b000};
        logic [2:0] r, v, sel;
        int l;
        void'($urandom(32'he97d5553));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFS_SETTLE_SEL, {29'h0, SETTLE_SEL_RESET});
        rd(OFS_CLOCK_CTRL, {29'h0, CLOCK_CTRL_RESET});
        rd(OFS_EVENTS, {29'h0, EVENTS_RESET});
        rd(8'h14, 32'h0);
        drain(20);
        $display("test register reset done");
        // Rows of rank, accept and in-service; don't-care bits are random.
        for (int k = 0; k < 5; k++) begin
            r = (rows[k] & ~dc[k]) | (3'($urandom) & dc[k]);
            pulse_halt();
            irq_u.raise({1'b1, r}, $urandom_range(0, 4));
            repeat (12) @(posedge hclk);
            look(11'h3F9);
            irq_u.unmask();
            if (r[1] && (!r[2] || r[0])) begin
                note("resume", {21'h0, 3'b100, 8'(WAIT_VECTORED_CLOCKS + 2)});
            end else begin
                note("resume", {21'h0, 3'b010, 8'(WAIT_NEXT_CLOCKS + 2)});
            end
            drain(40);
            look(11'h7F8);
        end
        rd(OFS_RELEASE_COUNT, 32'h5);
        $display("test halt release done");
        pulse_halt();
        repeat (3) @(posedge hclk);
        note("resume", {21'h0, 3'b001, 8'h0});
        irq_u.pulse_reset();
        drain(10);
        rd(OFS_EVENTS, 32'h6);
        bus(1'b1, OFS_EVENTS, 32'h7);
        rd(OFS_EVENTS, 32'h0);
        cpu_on_main_clock <= 1'b0;
        stop_exec <= 1'b1;
        @(posedge hclk);
        stop_exec <= 1'b0;
        look(11'h7F8);
        rd(OFS_EVENTS, 32'h1);
        cpu_on_main_clock <= 1'b1;
        drain(20);
        $display("test reset and refused stop done");
        // Pass 0 stops then wakes; pass 1 has the request already pending.
        for (int k = 0; k < 2; k++) begin
            v = 3'($urandom);
            sel = 3'($urandom);
            bus(1'b1, OFS_CLOCK_CTRL, {29'h0, v});
            bus(1'b1, OFS_SETTLE_SEL, {29'h0, sel});
            rd(OFS_SETTLE_SEL, {29'h0, sel});
            l = 4 << ((sel > SETTLE_SEL_MAX) ? SETTLE_SEL_MAX : sel);
            stop_exec <= 1'b1;
            if (k == 1) irq_u.raise(4'b0010, 0);
            @(posedge hclk);
            stop_exec <= 1'b0;
            if (k == 0) begin
                look({5'h00, v[0], v[1], v[2], 3'b111});
                repeat (10) @(posedge hclk);
                look({5'h00, v[0], v[1], v[2], 3'b111});
                irq_u.raise(4'b0010, 0);
            end else begin
                look({5'h0F, v[0], v[1], 4'b1001});
            end
            note("resume", {21'h0, 3'b100, 8'(l + WAIT_VECTORED_CLOCKS + 4)});
            drain(600);
            $display("test stop pass %0d done", k);
        end
        end_of_test();
    end
endmodule // tb_top
